// File: src/fan_ctrl_pkg.sv
// shared constants and types of the fan motor control block
package fan_ctrl_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned OSC_PERIOD_NS = 40;
	localparam int unsigned OSC_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOCK_TIME_MS = 500;
	localparam int unsigned AUTO_RESET_TIME_MS = 5000;
	localparam int unsigned INIT_TIME_US = 2000;
	localparam int unsigned HALL_MIN_FREQ_HZ = 7;
	localparam int unsigned LOCK_CYCLES_DEF = LOCK_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned AUTO_RESET_CYCLES_DEF = AUTO_RESET_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned INIT_CYCLES_DEF = INIT_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned HALL_SLOW_CYCLES_DEF = CLK_HZ / HALL_MIN_FREQ_HZ;
	// dc command: duty[%] = (97/3 * V - 88/3), valid 1 V .. 4 V
	localparam int unsigned DC_SLOPE = 97;
	localparam int unsigned DC_OFFSET = 88;
	localparam int unsigned DC_DENOM = 3;
	localparam int unsigned MV_PER_V = 1000;
	localparam int unsigned PERMILLE_PER_PCT = 10;
	localparam logic [15:0] DC_MIN_MV = 16'h03E8;
	localparam logic [15:0] DC_MAX_MV = 16'h0FA0;
	localparam logic [9:0] DUTY_FULL = 10'h3E8;
	localparam logic [9:0] CARRIER_LAST = 10'h3E7;
	localparam logic [9:0] STOP_TICKS = 10'h3E8;
	localparam logic [9:0] SS_TICKS_MAX = 10'h3E8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SPEED = 8'h04;
	localparam logic [7:0] ADDR_SST = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [15:0] SST_RESET = 16'h0010;
	localparam logic [1:0] FG_DIV_LOW = 2'h3;
	localparam logic [1:0] FG_DIV_MID = 2'h2;
	localparam logic [1:0] FG_DIV_HIGH = 2'h1;

	typedef enum logic [1:0] {LVL_LOW = 2'h0, LVL_MID = 2'h1, LVL_HIGH = 2'h2} level_t;
	typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_BRAKE = 2'h1, MODE_DRIVE = 2'h2} drive_mode_t;

	// control register, low bit first: sleep, dir[2:1], lock, phase, ov, fg[7:6], sst, dc
	typedef struct packed {
		logic dc_mode;
		logic soft_start_en;
		level_t speed_pulse_divider_select;
		logic overvoltage_level_select;
		logic phase_shift_select;
		logic lock_mode_select;
		level_t direction_brake_select;
		logic sleep;
	} ctrl_t;

	typedef struct packed {
		logic tsd;
		logic ocp;
		logic ovlo;
		logic uvlo;
	} fault_flags_t;
endpackage

// File: src/fan_ctrl.sv
// control and protection logic of a single-hall three-phase fan driver
//
// What this block does
// R01 - soft start widens the enabled pwm window by one osc tick every sst_period + 1 osc ticks
// R02 - dc command duty is 97/3 times volts minus 88/3 percent, 1 V to 4 V
// R03 - direction select: low forward, middle short-brake, high reverse
// R04 - sleep set enters sleep at once, phases and regulator off; clear leaves it
// R05 - in sleep no lock, voltage, current or thermal protection acts
// R06 - auto mode: 0.5 s without hall fall brakes, alarm low, released after 5 s
// R07 - auto mode lock clears on hall fall, command start, undervoltage or sleep
// R08 - latch mode: lock after 0.5 s holds until undervoltage or sleep
// R09 - undervoltage flag forces short-brake until it clears
// R10 - overvoltage flag forces short-brake; threshold level follows select bit
// R11 - overcurrent flag forces short-brake until it clears
// R12 - thermal flag turns all phases off until it clears
// R13 - phase select low gives automatic phase correction, high a constant phase
// R14 - the host changes phase select only while the motor stands still
// R15 - speed pulse is one cycle per 3, 2 or 1 hall cycles by divider select
// R16 - soft start applies only when enabled, else full duty at once
// R17 - command is a pwm pin in pwm mode or a dc voltage against a sawtooth carrier
// R18 - after undervoltage release or sleep exit hold outputs off for 2 ms
// R19 - on stop, phases off above 7 Hz hall rate, short-brake below
// R20 - pwm command pin is sampled every 40 ns internal oscillator tick
// R21 - sleep and thermal off beat short-brake, short-brake beats drive
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fan_ctrl #(
	parameter int unsigned LOCK_CYCLES = fan_ctrl_pkg::LOCK_CYCLES_DEF,
	parameter int unsigned AUTO_RESET_CYCLES = fan_ctrl_pkg::AUTO_RESET_CYCLES_DEF,
	parameter int unsigned INIT_CYCLES = fan_ctrl_pkg::INIT_CYCLES_DEF,
	parameter int unsigned HALL_SLOW_CYCLES = fan_ctrl_pkg::HALL_SLOW_CYCLES_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic speed_command_input,
	input wire logic hall_positive_input,
	input wire logic hall_negative_input,
	input wire fan_ctrl_pkg::fault_flags_t faults,
	output fan_ctrl_pkg::drive_mode_t drive_mode,
	output logic pwm_out,
	output logic reverse,
	output logic auto_phase_correct,
	output logic ov_level_high,
	output logic regulator_output,
	output logic speed_pulse_output,
	output logic lock_alarm_output
);
	import fan_ctrl_pkg::*;

	typedef enum logic {LOCK_RUN, LOCK_TRIP} lock_state_t;

	ctrl_t ctrl;
	logic [15:0] speed_mv;
	logic [15:0] sst_period;
	lock_state_t lock_state;
	logic [31:0] lock_cnt;
	logic [31:0] init_cnt;
	logic init_busy;
	logic [31:0] hall_age;
	logic hall_diff;
	logic hall_prev;
	logic [2:0] osc_cnt;
	logic [9:0] carrier;
	logic cmd_pin;
	logic cmd_prev;
	logic [9:0] low_ticks;
	logic stopped;
	logic stop_prev;
	logic [9:0] window;
	logic [9:0] ss_ticks;
	logic [15:0] ss_cnt;
	logic ss_active;
	logic [1:0] fg_cnt;
	drive_mode_t next_mode;
	logic next_cmd;
	logic [9:0] dc_duty;
	logic [31:0] next_status;
	logic osc_tick;
	logic hall_fall;
	logic hall_edge;
	logic cmd_start;
	logic lock_release;
	logic protect_on;
	logic apb_setup;
	logic apb_write;

	// dc voltage to duty in tenths of a percent, zero below 1 V and full duty from 4 V up
	function automatic logic [9:0] dc_to_permille(input logic [15:0] mv);
		logic [31:0] num;
		num = 32'(DC_SLOPE) * 32'(mv) - 32'(DC_OFFSET * MV_PER_V);
		if (mv <= DC_MIN_MV) begin
			dc_to_permille = (mv == DC_MIN_MV) ? 10'(num / (DC_DENOM * MV_PER_V / PERMILLE_PER_PCT)) : '0;
		end else if (mv >= DC_MAX_MV) begin
			dc_to_permille = DUTY_FULL;
		end else begin
			dc_to_permille = 10'(num / (DC_DENOM * MV_PER_V / PERMILLE_PER_PCT));
		end
	endfunction

	// hall edges per toggle of the speed pulse; two toggles make one cycle
	function automatic logic [1:0] fg_edges(input level_t sel);
		unique case (sel)
			LVL_LOW: fg_edges = FG_DIV_LOW;
			LVL_HIGH: fg_edges = FG_DIV_HIGH;
			default: fg_edges = FG_DIV_MID;
		endcase
	endfunction

	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready && pwrite;
	assign osc_tick = (osc_cnt == 3'(OSC_CYCLES - 1));
	assign hall_fall = hall_prev && !hall_diff;
	assign hall_edge = hall_prev != hall_diff;
	assign cmd_start = stop_prev && !stopped;
	// every protection is idle while asleep
	// R05 - protections gated
	assign protect_on = !ctrl.sleep;
	// R07 - auto release events
	assign lock_release = faults.uvlo || ctrl.sleep ||
		(!ctrl.lock_mode_select && (hall_fall || cmd_start ||
		lock_cnt >= 32'(AUTO_RESET_CYCLES)));
	// R02 - dc duty mapping
	assign dc_duty = dc_to_permille(speed_mv);

	// zero-wait slave: data and error latched in setup, ready in first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && !(paddr inside {ADDR_CTRL, ADDR_SPEED, ADDR_SST, ADDR_STATUS});
			if (apb_setup) begin
				unique case (paddr)
					ADDR_CTRL: prdata <= 32'(ctrl);
					ADDR_SPEED: prdata <= 32'(speed_mv);
					ADDR_SST: prdata <= 32'(sst_period);
					ADDR_STATUS: prdata <= next_status;
					default: prdata <= '0;
				endcase
			end
		end
	end

	always_comb begin
		next_status = {19'h0, stopped, ss_active, init_busy, (hall_age < 32'(HALL_SLOW_CYCLES)),
			lock_state == LOCK_TRIP, 2'(drive_mode), 1'b0, faults, 1'b0};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
			speed_mv <= '0;
			sst_period <= SST_RESET;
		end else if (apb_write) begin
			if (paddr == ADDR_CTRL) begin
				ctrl <= ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
			end
			if (paddr == ADDR_SPEED) begin
				speed_mv <= pwdata[15:0];
			end
			if (paddr == ADDR_SST) begin
				sst_period <= pwdata[15:0];
			end
		end
	end

	// R20 - 40 ns command sampling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt <= '0;
			cmd_pin <= 1'b0;
			carrier <= '0;
		end else begin
			osc_cnt <= osc_tick ? '0 : osc_cnt + 3'h1;
			if (osc_tick) begin
				cmd_pin <= speed_command_input;
				carrier <= (carrier == CARRIER_LAST) ? '0 : carrier + 10'h1;
			end
		end
	end

	// stop detection: zero dc duty, or pin low for a whole carrier period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_ticks <= '0;
			stopped <= 1'b1;
			stop_prev <= 1'b1;
		end else begin
			stop_prev <= stopped;
			if (osc_tick) begin
				low_ticks <= cmd_pin ? '0 : ((low_ticks == STOP_TICKS) ? low_ticks : low_ticks + 10'h1);
			end
			stopped <= ctrl.dc_mode ? (dc_duty == '0) : (low_ticks == STOP_TICKS);
		end
	end

	// R17 - command source select
	always_comb begin
		next_cmd = ctrl.dc_mode ? (carrier < dc_duty) : cmd_pin;
	end

	// R01 - soft start window ramp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_prev <= 1'b0;
			window <= '0;
			ss_ticks <= '0;
			ss_cnt <= '0;
			ss_active <= 1'b1;
		end else begin
			cmd_prev <= next_cmd;
			if (next_cmd && !cmd_prev) begin
				window <= '0;
			end else if (osc_tick && window != SS_TICKS_MAX) begin
				window <= window + 10'h1;
			end
			if (init_busy) begin
				ss_ticks <= '0;
				ss_cnt <= '0;
				ss_active <= 1'b1;
			end else if (!ctrl.soft_start_en || ss_ticks == SS_TICKS_MAX) begin
				// R16 - soft start bypass
				ss_active <= 1'b0;
			end else if (osc_tick) begin
				if (ss_cnt >= sst_period) begin
					ss_cnt <= '0;
					ss_ticks <= ss_ticks + 10'h1;
				end else begin
					ss_cnt <= ss_cnt + 16'h1;
				end
			end
		end
	end

	// R18 - init hold after wake or supply recovery
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt <= '0;
			init_busy <= 1'b1;
		end else begin
			if (ctrl.sleep || faults.uvlo) begin
				init_cnt <= '0;
				init_busy <= 1'b1;
			end else if (init_cnt >= 32'(INIT_CYCLES - 1)) begin
				init_busy <= 1'b0;
			end else begin
				init_cnt <= init_cnt + 32'h1;
			end
		end
	end

	// hall comparator and age since last falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hall_diff <= 1'b0;
			hall_prev <= 1'b0;
			hall_age <= '1;
		end else begin
			hall_diff <= hall_positive_input && !hall_negative_input;
			hall_prev <= hall_diff;
			if (hall_fall) begin
				hall_age <= '0;
			end else if (hall_age != '1) begin
				hall_age <= hall_age + 32'h1;
			end
		end
	end

	// R06 - lock timeout and auto reset
	// R08 - latch mode hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_state <= LOCK_RUN;
			lock_cnt <= '0;
		end else begin
			unique case (lock_state)
				LOCK_RUN: begin
					if (!protect_on || init_busy || stopped || hall_fall) begin
						lock_cnt <= '0;
					end else if (lock_cnt >= 32'(LOCK_CYCLES - 1)) begin
						lock_state <= LOCK_TRIP;
						lock_cnt <= '0;
					end else begin
						lock_cnt <= lock_cnt + 32'h1;
					end
				end
				LOCK_TRIP: begin
					if (lock_release) begin
						lock_state <= LOCK_RUN;
						lock_cnt <= '0;
					end else begin
						lock_cnt <= lock_cnt + 32'h1;
					end
				end
			endcase
		end
	end

	// R21 - output priority
	always_comb begin
		// undervoltage keeps braking although it also rearms the init hold
		if (ctrl.sleep || (protect_on && faults.tsd) || (init_busy && !faults.uvlo)) begin
			// R04 - sleep all off
			// R12 - thermal all off
			next_mode = MODE_OFF;
		end else if ((protect_on && (faults.uvlo || faults.ovlo || faults.ocp)) ||
			lock_state == LOCK_TRIP || ctrl.direction_brake_select == LVL_MID) begin
			// R03 - middle level brakes
			// R09 - undervoltage brake
			// R10 - overvoltage brake
			// R11 - overcurrent brake
			next_mode = MODE_BRAKE;
		end else if (stopped) begin
			// R19 - stop coast or brake
			next_mode = (hall_age < 32'(HALL_SLOW_CYCLES)) ? MODE_OFF : MODE_BRAKE;
		end else begin
			next_mode = MODE_DRIVE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_mode <= MODE_OFF;
			pwm_out <= 1'b0;
			reverse <= 1'b0;
			auto_phase_correct <= 1'b1;
			ov_level_high <= 1'b0;
			regulator_output <= 1'b0;
			lock_alarm_output <= 1'b1;
		end else begin
			drive_mode <= next_mode;
			pwm_out <= next_mode == MODE_DRIVE && next_cmd && (!ss_active || window < ss_ticks);
			// R03 - direction decode
			reverse <= ctrl.direction_brake_select == LVL_HIGH;
			// R13 - phase correction select
			auto_phase_correct <= !ctrl.phase_shift_select;
			ov_level_high <= ctrl.overvoltage_level_select;
			regulator_output <= !ctrl.sleep;
			lock_alarm_output <= lock_state != LOCK_TRIP;
		end
	end

	// R15 - speed pulse divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fg_cnt <= '0;
			speed_pulse_output <= 1'b0;
		end else if (hall_edge) begin
			if (fg_cnt + 2'h1 >= fg_edges(ctrl.speed_pulse_divider_select)) begin
				fg_cnt <= '0;
				speed_pulse_output <= !speed_pulse_output;
			end else begin
				fg_cnt <= fg_cnt + 2'h1;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sleep_all_off_a: assert property (ctrl.sleep |=> drive_mode == MODE_OFF && !regulator_output) else $error("sleep did not turn outputs off"); // R04
	thermal_off_a: assert property (faults.tsd && !ctrl.sleep |=> drive_mode == MODE_OFF) else $error("thermal flag did not turn phases off"); // R12
	fault_brake_a: assert property ((faults.uvlo || faults.ovlo || faults.ocp) && !ctrl.sleep && !faults.tsd && !init_busy |=> drive_mode == MODE_BRAKE) else $error("fault did not brake"); // R11
	mid_brake_a: assert property (ctrl.direction_brake_select == LVL_MID && !ctrl.sleep && !faults.tsd && !init_busy |=> drive_mode == MODE_BRAKE) else $error("middle level did not brake"); // R03
	lock_brake_alarm_a: assert property (lock_state == LOCK_TRIP && !ctrl.sleep && !faults.tsd |=> !lock_alarm_output && drive_mode == MODE_BRAKE) else $error("lock did not brake with alarm low"); // R06
	latch_hold_a: assert property (lock_state == LOCK_TRIP && ctrl.lock_mode_select && !faults.uvlo && !ctrl.sleep |=> lock_state == LOCK_TRIP) else $error("latched lock released early"); // R08
	auto_release_a: assert property (lock_state == LOCK_TRIP && !ctrl.lock_mode_select && hall_fall |=> lock_state == LOCK_RUN ##1 lock_alarm_output) else $error("auto lock not released by hall"); // R07
	wake_init_a: assert property ($fell(ctrl.sleep) |-> init_busy [*2] ##1 drive_mode == MODE_OFF) else $error("no init hold after sleep exit"); // R18
	pwm_only_drive_a: assert property (pwm_out |-> drive_mode == MODE_DRIVE) else $error("pwm active outside drive"); // R21
	fg_on_edge_a: assert property ($changed(speed_pulse_output) |-> $past(hall_edge)) else $error("speed pulse moved without hall edge"); // R15
	dc_range_a: assert property (ctrl.dc_mode |-> dc_duty <= DUTY_FULL) else $error("dc duty out of range"); // R02

	lock_trip_c: cover property (lock_state == LOCK_RUN ##1 lock_state == LOCK_TRIP);
	drive_c: cover property (drive_mode == MODE_DRIVE && pwm_out);
	coast_c: cover property (stopped && drive_mode == MODE_OFF && !init_busy);
	ss_done_c: cover property ($fell(ss_active));
endmodule
`default_nettype wire

// File: verification/hall_model.sv
// hall sensor model: square wave across the comparator pair
`timescale 1ns/1ps
`default_nettype none
module hall_model #(
	parameter int unsigned HALF = 40
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic hall_positive_input,
	output logic hall_negative_input
);
	int unsigned cnt;
	// a stalled rotor keeps its last level, so no edge reaches the lock timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			hall_positive_input <= 1'b0;
		end else if (run) begin
			if (cnt == HALF - 1) begin
				cnt <= 0;
				hall_positive_input <= !hall_positive_input;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
	assign hall_negative_input = !hall_positive_input;
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench of the fan control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fan_ctrl_pkg::*;
	localparam int unsigned LK = 200;
	localparam int unsigned AR = 1000;
	localparam int unsigned IN = 50;
	localparam int unsigned HS = 300;
	logic pclk, presetn, psel, penable, pwrite, speed_command_input, run, err, prev;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, hp, hn, pwm_out, reverse, auto_phase_correct, ov_level_high;
	logic regulator_output, speed_pulse_output, lock_alarm_output;
	fault_flags_t faults;
	drive_mode_t drive_mode;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int tg, e;
	logic [3:0] ft [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h9};
	drive_mode_t fm [5] = '{MODE_BRAKE, MODE_BRAKE, MODE_BRAKE, MODE_OFF, MODE_OFF};

	fan_ctrl #(.LOCK_CYCLES(LK), .AUTO_RESET_CYCLES(AR), .INIT_CYCLES(IN),
		.HALL_SLOW_CYCLES(HS)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.speed_command_input(speed_command_input), .hall_positive_input(hp),
		.hall_negative_input(hn), .faults(faults), .drive_mode(drive_mode),
		.pwm_out(pwm_out), .reverse(reverse), .auto_phase_correct(auto_phase_correct),
		.ov_level_high(ov_level_high), .regulator_output(regulator_output),
		.speed_pulse_output(speed_pulse_output), .lock_alarm_output(lock_alarm_output));
	hall_model #(.HALF(40)) u_hall (.pclk(pclk), .presetn(presetn), .run(run),
		.hall_positive_input(hp), .hall_negative_input(hn));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard, well above the few tens of thousands of cycles needed
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			$display("mismatch at %0t: run timed out", $time);
			tally_and_finish();
		end
	end

	task ck(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task ck1(input logic seen, input logic exp);
		ck({31'h0, seen}, {31'h0, exp});
	endtask

	task md(input drive_mode_t m);
		ck({30'h0, drive_mode}, {30'h0, m});
	endtask

	task w(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// master holds the request until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task trip();
		w(LK + IN + 20);
		ck1(lock_alarm_output, 1'b0);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		speed_command_input = 1'b0;
		run = 1'b0;
		faults = '0;
		w(8);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		ck(q, 32'h0);
		apb(1'b0, ADDR_SST, 32'h0);
		ck(q, {16'h0, SST_RESET});
		ck1(regulator_output, 1'b1);
		ck1(lock_alarm_output, 1'b1);
		ck1(auto_phase_correct, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		ck({err, q[30:0]}, 32'h8000_0000);
		apb(1'b1, ADDR_SPEED, 32'hABCD_1F40);
		apb(1'b0, ADDR_SPEED, 32'h0);
		ck(q, 32'h1F40);
		apb(1'b1, ADDR_SPEED, 32'h0);
		// phase select changes only with the motor stopped
		apb(1'b1, ADDR_CTRL, 32'hFFFF_F2B4);
		apb(1'b0, ADDR_CTRL, 32'h0);
		ck(q, 32'h2B4);
		ck({reverse, auto_phase_correct, ov_level_high}, 3'b101);
		apb(1'b1, ADDR_CTRL, 32'h200);
		w(HS + IN + 20);
		md(MODE_BRAKE);
		run <= 1'b1;
		w(200);
		md(MODE_OFF);
		apb(1'b1, ADDR_SPEED, 32'h3E7);
		w(20);
		md(MODE_OFF);
		apb(1'b1, ADDR_SPEED, 32'h3E8);
		w(20);
		md(MODE_DRIVE);
		apb(1'b1, ADDR_SPEED, 32'hFA0);
		w(20);
		ck1(pwm_out, 1'b1);
		for (int i = 0; i < 5; i++) begin
			faults <= fault_flags_t'(ft[i]);
			w(3);
			md(fm[i]);
			faults <= '0;
			w(10);
			md(ft[i][0] ? MODE_OFF : MODE_DRIVE);
			w(IN + 10);
			md(MODE_DRIVE);
		end
		apb(1'b1, ADDR_CTRL, 32'h202);
		w(3);
		md(MODE_BRAKE);
		apb(1'b1, ADDR_CTRL, 32'h204);
		w(3);
		ck1(reverse, 1'b1);
		md(MODE_DRIVE);
		for (int f = 0; f < 3; f++) begin
			apb(1'b1, ADDR_CTRL, 32'h200 | (f << 6));
			e = 48 / (3 - f);
			tg = 0;
			prev = speed_pulse_output;
			repeat (1920) begin
				@(posedge pclk);
				if (speed_pulse_output !== prev) tg++;
				prev = speed_pulse_output;
			end
			ck1(tg >= e - 1 && tg <= e + 1, 1'b1);
		end
		apb(1'b1, ADDR_CTRL, 32'h200);
		run <= 1'b0;
		trip();
		md(MODE_BRAKE);
		w(AR - 40);
		ck1(lock_alarm_output, 1'b1);
		trip();
		run <= 1'b1;
		w(100);
		ck1(lock_alarm_output, 1'b1);
		run <= 1'b0;
		trip();
		apb(1'b1, ADDR_SPEED, 32'h0);
		apb(1'b1, ADDR_SPEED, 32'hFA0);
		w(5);
		ck1(lock_alarm_output, 1'b1);
		trip();
		faults <= fault_flags_t'(4'h1);
		w(3);
		ck1(lock_alarm_output, 1'b1);
		faults <= '0;
		trip();
		apb(1'b1, ADDR_CTRL, 32'h201);
		w(3);
		ck1(lock_alarm_output, 1'b1);
		ck1(regulator_output, 1'b0);
		md(MODE_OFF);
		faults <= fault_flags_t'(4'h4);
		w(LK + 60);
		ck1(lock_alarm_output, 1'b1);
		md(MODE_OFF);
		faults <= '0;
		apb(1'b1, ADDR_CTRL, 32'h208);
		w(10);
		ck1(regulator_output, 1'b1);
		md(MODE_OFF);
		trip();
		w(AR + 100);
		ck1(lock_alarm_output, 1'b0);
		run <= 1'b1;
		w(100);
		ck1(lock_alarm_output, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h209);
		w(3);
		ck1(lock_alarm_output, 1'b1);
		run <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h208);
		trip();
		faults <= fault_flags_t'(4'h1);
		w(3);
		ck1(lock_alarm_output, 1'b1);
		faults <= '0;
		run <= 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h0);
		speed_command_input <= 1'b1;
		w(IN + 40);
		md(MODE_DRIVE);
		// soft start rearmed by a wake, one ramp step per oscillator tick
		apb(1'b1, ADDR_SST, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h101);
		apb(1'b1, ADDR_CTRL, 32'h100);
		w(IN + 40);
		apb(1'b0, ADDR_STATUS, 32'h0);
		ck(q[12:10], 3'b010);
		ck1(pwm_out, 1'b0);
		w(8100);
		ck1(pwm_out, 1'b1);
		speed_command_input <= 1'b0;
		w(8100);
		md(MODE_OFF);
		tally_and_finish();
	end
endmodule
`default_nettype wire
